/* core/dig_io_regs.sv */
// Digital audio input/output configuration registers and their decoded controls.
// Assumes the serial control interface presents one-cycle write/read strobes on ref_clk,
// a clock separate from the audio path clocks.
// The divider, mode and source-valid inputs come from logic on the same clock,
// so they pass no synchroniser.
// Decoded outputs follow the stored fields one cycle after a write.
//
// Contract
// - Mute bit 8 set mutes digital output.
// - Output power bit 7, default on.
// - Registers run on own clock.
// - Two-bit source select: ADC, serial, receiver, mixer.
// - Invalid selected source falls back to default.
// - Output format: I2S, LSB 16-24, MSB.
// - Output codes 110/111 use default format.
// - Input power bit 7, default on.
// - Four-bit application mode decoded zero to fifteen.
// - Input format same encoding, unused gives default.
// - Divider picks fs, 256/384, bit clock.
module dig_io_regs (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic resetn,

  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,

  // Neighbouring clock register fields
  input wire logic [4:0] crystal_divider_field,
  input wire logic [3:0] app_mode_field,

  // Source validity from the application
  input wire logic [3:0] src_valid,

  // Decoded output controls
  output logic output_mute_bit,
  output logic output_power_bit,
  output dig_io_pkg::out_src_t output_source_select,
  output dig_io_pkg::ser_fmt_t output_format_field,
  output logic input_power_bit,
  output dig_io_pkg::ser_fmt_t input_format_field,

  // Crystal divider and mode decode
  output dig_io_pkg::fs48_t fs48_sel,
  output logic sysclk_384,
  output logic bck_48fs,
  output logic [15:0] app_mode_onehot
);
  import dig_io_pkg::*;

  // Register images; reserved bits are never stored
  logic [15:0] out_ctrl_q;
  logic [15:0] out_ctrl_d;
  logic [15:0] in_ctrl_q;
  logic [15:0] in_ctrl_d;

  // Address decode and write strobes
  logic out_hit;
  logic in_hit;
  logic wr_out;
  logic wr_in;

  // Read path
  logic [15:0] rdata_d;

  // Raw fields as stored
  logic [2:0] ofmt_raw;
  logic [2:0] ifmt_raw;
  logic [1:0] src_raw;

  // Effective values after fallback
  logic src_ok;
  out_src_t src_d;
  ser_fmt_t ofmt_d;
  ser_fmt_t ifmt_d;

  // Clock register fields as seen here
  logic [4:0] xdiv;
  logic ratio_384;
  fs48_t fs_d;
  logic [15:0] mode_d;

  assign out_hit = (reg_addr == out_ctrl_addr);
  assign in_hit = (reg_addr == in_ctrl_addr);
  assign wr_out = reg_wr && out_hit;
  assign wr_in = reg_wr && in_hit;

  // Reserved bits are dropped on the way in, so nothing downstream ever sees them
  always_comb begin
    out_ctrl_d = out_ctrl_q;
    if (wr_out) begin
      out_ctrl_d = reg_wdata & out_ctrl_mask;
    end
  end

  always_comb begin
    in_ctrl_d = in_ctrl_q;
    if (wr_in) begin
      in_ctrl_d = reg_wdata & in_ctrl_mask;
    end
  end

  // All state is on ref_clk, never on audio clocks, so power-down cannot stall access
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      out_ctrl_q <= out_ctrl_reset;
    end else begin
      out_ctrl_q <= out_ctrl_d;
    end
  end

  // Input register: power bit and format only
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      in_ctrl_q <= in_ctrl_reset;
    end else begin
      in_ctrl_q <= in_ctrl_d;
    end
  end

  // Unmapped addresses read as zero; a read in a write's cycle returns the old value
  always_comb begin
    rdata_d = 16'h0000;
    if (out_hit) begin
      rdata_d = out_ctrl_q & out_ctrl_mask;
    end else if (in_hit) begin
      rdata_d = in_ctrl_q & in_ctrl_mask;
    end
  end

  // Read valid is a one-cycle pulse after each read strobe
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
    end
  end

  // Read data holds until the next read
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rdata_d;
    end
  end

  // Decoded controls follow the stored fields one cycle after a write
  assign ofmt_raw = out_ctrl_q[fmt_lsb +: 3];
  assign ifmt_raw = in_ctrl_q[fmt_lsb +: 3];
  assign src_raw = out_ctrl_q[src_lsb +: 2];

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_mute_bit <= out_ctrl_reset[mute_pos];
    end else begin
      output_mute_bit <= out_ctrl_q[mute_pos];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_power_bit <= out_ctrl_reset[pwr_pos];
    end else begin
      output_power_bit <= out_ctrl_q[pwr_pos];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      input_power_bit <= in_ctrl_reset[pwr_pos];
    end else begin
      input_power_bit <= in_ctrl_q[pwr_pos];
    end
  end

  // A source the application marks invalid is replaced by the default path
  assign src_ok = src_valid[src_raw];

  always_comb begin
    unique case (src_raw)
      2'h0: src_d = src_adc;
      2'h1: src_d = src_serial_in;
      2'h2: src_d = src_spdif_rx;
      2'h3: src_d = src_mixer;
    endcase
    if (!src_ok) begin
      src_d = out_src_t'(src_default);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_source_select <= out_src_t'(src_default);
    end else begin
      output_source_select <= src_d;
    end
  end

  // Codes 110 and 111 are unused and fall back to the default format
  always_comb begin
    unique case (ofmt_raw)
      3'h0: ofmt_d = fmt_i2s;
      3'h1: ofmt_d = fmt_lsb16;
      3'h2: ofmt_d = fmt_lsb18;
      3'h3: ofmt_d = fmt_lsb20;
      3'h4: ofmt_d = fmt_lsb24;
      3'h5: ofmt_d = fmt_msb;
      default: ofmt_d = ser_fmt_t'(fmt_default);
    endcase
  end

  always_comb begin
    unique case (ifmt_raw)
      3'h0: ifmt_d = fmt_i2s;
      3'h1: ifmt_d = fmt_lsb16;
      3'h2: ifmt_d = fmt_lsb18;
      3'h3: ifmt_d = fmt_lsb20;
      3'h4: ifmt_d = fmt_lsb24;
      3'h5: ifmt_d = fmt_msb;
      default: ifmt_d = ser_fmt_t'(fmt_default);
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      output_format_field <= ser_fmt_t'(fmt_default);
    end else begin
      output_format_field <= ofmt_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      input_format_field <= ser_fmt_t'(fmt_default);
    end else begin
      input_format_field <= ifmt_d;
    end
  end

  // Only the 48 kHz family is decoded here; other codes report no rate
  assign xdiv = crystal_divider_field;

  // Bit 0 picks 384 fs in every family, and with it a 48 fs bit clock
  assign ratio_384 = xdiv[0];

  always_comb begin
    unique case (xdiv[4:1])
      4'h6: fs_d = fs_24k;
      4'h7: fs_d = fs_48k;
      4'h8: fs_d = fs_96k;
      default: fs_d = fs_none;
    endcase
  end

  // Rate code is registered alongside the ratio flags
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      fs48_sel <= fs_48k;
    end else begin
      fs48_sel <= fs_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      sysclk_384 <= xtl_div_reset[0];
    end else begin
      sysclk_384 <= ratio_384;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      bck_48fs <= xtl_div_reset[0];
    end else begin
      bck_48fs <= ratio_384;
    end
  end

  // One decoder bit per mode; exactly one is high for any field value
  for (genvar m = 0; m < 16; m++) begin : g_mode
    assign mode_d[m] = (app_mode_field == 4'(m));
  end

  // Registered so the mode output, like every output, comes from a flop
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      app_mode_onehot <= 16'h0001 << app_mode_reset;
    end else begin
      app_mode_onehot <= mode_d;
    end
  end
endmodule

/* core/dig_io_pkg.sv */
// Constants for the digital audio I/O configuration registers.
// Assumes a register write/read port driven by the serial control interface logic.
package dig_io_pkg;
  localparam logic [7:0] out_ctrl_addr = 8'h01;
  localparam logic [7:0] in_ctrl_addr = 8'h02;
  localparam logic [15:0] out_ctrl_reset = 16'h00a0;
  localparam logic [15:0] in_ctrl_reset = 16'h0080;
  localparam logic [15:0] out_ctrl_mask = 16'h01b7;
  localparam logic [15:0] in_ctrl_mask = 16'h0087;
  localparam int mute_pos = 8;
  localparam int pwr_pos = 7;
  localparam int src_lsb = 4;
  localparam int fmt_lsb = 0;
  localparam logic [2:0] fmt_default = 3'h0;
  localparam logic [2:0] fmt_last_valid = 3'h5;
  localparam logic [1:0] src_default = 2'h0;
  localparam logic [4:0] xtl_div_reset = 5'h08;
  localparam logic [3:0] app_mode_reset = 4'h2;
  typedef enum logic [1:0] {
    src_adc = 2'h0,
    src_serial_in = 2'h1,
    src_spdif_rx = 2'h2,
    src_mixer = 2'h3
  } out_src_t;
  typedef enum logic [2:0] {
    fmt_i2s = 3'h0,
    fmt_lsb16 = 3'h1,
    fmt_lsb18 = 3'h2,
    fmt_lsb20 = 3'h3,
    fmt_lsb24 = 3'h4,
    fmt_msb = 3'h5
  } ser_fmt_t;
  typedef enum logic [2:0] {
    fs_none = 3'h0,
    fs_24k = 3'h1,
    fs_48k = 3'h2,
    fs_96k = 3'h3
  } fs48_t;
endpackage

/* testbench/dig_io_regs_monitor.sv */
// Checker for the digital audio I/O configuration registers.
// Assumes it is bound to dig_io_regs and sees its ports by name.
module dig_io_regs_monitor import dig_io_pkg::*; (
  input wire logic ref_clk, resetn, reg_wr, reg_rd, reg_rvalid,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata, reg_rdata, app_mode_onehot,
  input wire logic [4:0] crystal_divider_field,
  input wire logic [3:0] app_mode_field,
  input wire logic output_mute_bit, output_power_bit, input_power_bit, sysclk_384, bck_48fs,
  input wire ser_fmt_t output_format_field,
  input wire fs48_t fs48_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire wo = reg_wr && reg_addr == out_ctrl_addr;
  wire wi = reg_wr && reg_addr == in_ctrl_addr;
  property p_mute; wo |-> ##2 output_mute_bit == $past(reg_wdata[8], 2); endproperty
  a_mute: assert property (p_mute) else $error("mute mismatch");
  property p_opwr; wo |-> ##2 output_power_bit == $past(reg_wdata[7], 2); endproperty
  a_opwr: assert property (p_opwr) else $error("output power mismatch");
  property p_ipwr; wi |-> ##2 input_power_bit == $past(reg_wdata[7], 2); endproperty
  a_ipwr: assert property (p_ipwr) else $error("input power mismatch");
  property p_fmt;
    wo && reg_wdata[2:0] <= fmt_last_valid |-> ##2 output_format_field == $past(reg_wdata[2:0], 2);
  endproperty
  a_fmt: assert property (p_fmt) else $error("format mismatch");
  property p_unused;
    wo && reg_wdata[2:0] > fmt_last_valid |-> ##2 output_format_field == fmt_default;
  endproperty
  a_unused: assert property (p_unused) else $error("unused format kept");
  property p_rsv; reg_rd |=> reg_rvalid && (reg_rdata & ~out_ctrl_mask) == 16'h0000; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits read nonzero");
  property p_mode;
    $past(resetn) |-> app_mode_onehot == 16'h0001 << $past(app_mode_field);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_div;
    $past(resetn) |-> sysclk_384 == $past(crystal_divider_field[0]) && bck_48fs == sysclk_384;
  endproperty
  a_div: assert property (p_div) else $error("divider ratio wrong");
  property p_fs48;
    $past(resetn) && $past(crystal_divider_field) == 5'h0e |-> fs48_sel == fs_48k;
  endproperty
  a_fs48: assert property (p_fs48) else $error("48k decode wrong");
  c_wo: cover property (wo);
  c_rd: cover property (reg_rd && reg_addr == in_ctrl_addr);
  c_fs: cover property (fs48_sel == fs_96k);
endmodule

/* testbench/dig_io_regs_tb_top.sv */
// Self-checking bench for the digital audio I/O configuration registers.
// Assumes the register port strobes are single-cycle and taken on ref_clk.
module dig_io_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import dig_io_pkg::*;
  logic ref_clk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [4:0] crystal_divider_field = 5'h08;
  logic [3:0] app_mode_field = 4'h2, src_valid = 4'hf;
  wire [15:0] reg_rdata, app_mode_onehot;
  wire reg_rvalid, output_mute_bit, output_power_bit, input_power_bit, sysclk_384, bck_48fs;
  out_src_t output_source_select;
  ser_fmt_t output_format_field, input_format_field;
  fs48_t fs48_sel;
  int fails = 0, n_checks = 0;
  wire [15:0] ov = {7'h00, output_mute_bit, output_power_bit, 1'b0, output_source_select, 1'b0,
    output_format_field};
  wire [15:0] iv = {8'h00, input_power_bit, 4'h0, input_format_field};
  always #5 ref_clk = ~ref_clk;
  dig_io_regs i_dig_io_regs (.*);
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge ref_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge ref_clk);
    reg_wr = 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(negedge ref_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge ref_clk);
    reg_rd = 1'b0;
    chk({15'h0000, reg_rvalid}, 16'h0001);
    chk(reg_rdata, e);
  endtask
  task automatic t_out;
    for (int i = 0; i < 8; i++) begin
      wr(8'h01, 16'(((i % 4) << 4) | i));
      chk(ov, 16'(((i % 4) << 4) | (i > 5 ? 0 : i)));
    end
    src_valid = 4'h7;
    wr(8'h01, 16'hfff6);
    chk(ov, 16'h0180);
    rd(8'h01, 16'h01b6);
  endtask
  task automatic t_in;
    wr(8'h02, 16'hff43);
    chk(iv, 16'h0003);
    rd(8'h02, 16'h0003);
    wr(8'h02, 16'h0086);
    chk(iv, 16'h0080);
    rd(8'h03, 16'h0000);
  endtask
  task automatic t_clk;
    for (int c = 11; c < 19; c++) begin
      crystal_divider_field = 5'(c);
      @(negedge ref_clk);
      chk({11'h000, fs48_sel, sysclk_384, bck_48fs},
        16'({(c < 12 || c > 17) ? 0 : (c - 10) / 2, c[0], c[0]}));
    end
    for (int m = 0; m < 16; m++) begin
      app_mode_field = 4'(m);
      @(negedge ref_clk);
      chk(app_mode_onehot, 16'h0001 << m);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    rd(8'h01, 16'h00a0);
    rd(8'h02, 16'h0080);
    t_out;
    t_in;
    t_clk;
    report_and_stop;
  end
endmodule
bind dig_io_regs dig_io_regs_monitor i_dig_io_regs_monitor (.*);
